// file: include/acr_pkg.sv
package acr_pkg;
    localparam int          ACR_AW            = 5;
    localparam logic [4:0]  OFF_PORT_CONTROL  = 5'h00;
    localparam logic [4:0]  OFF_RX_QUEUE      = 5'h00;
    localparam logic [4:0]  OFF_TX_QUEUE      = 5'h04;
    localparam logic [4:0]  OFF_CLOCK_CHECK   = 5'h14;
    localparam logic [4:0]  OFF_ERR_ENABLE    = 5'h18;
    localparam logic [4:0]  OFF_ERR_PENDING   = 5'h1C;
    localparam int          POS_BYTE_ORDER    = 31;
    localparam int          POS_SLAVE_IDENTIFIER_HI       = 28;
    localparam int          POS_SLAVE_IDENTIFIER_LO       = 24;
    localparam int          POS_TXUDC_HI      = 21;
    localparam int          POS_TXUDC_LO      = 18;
    localparam int          POS_TX_EN         = 16;
    localparam int          POS_SHARED        = 14;
    localparam int          POS_RXUDC_HI      = 5;
    localparam int          POS_RXUDC_LO      = 2;
    localparam int          POS_RX_EN         = 0;
    localparam logic [31:0] CTRL_WMASK        = 32'h9F3D403D;
    localparam logic [31:0] CTRL_RESET        = 32'h00004000;
    localparam logic [4:0]  NULL_SLAVE        = 5'h1F;
    localparam logic [3:0]  UDC_MAX           = 4'hB;
    localparam logic [6:0]  STD_CELL_BYTES    = 7'h35;
    localparam logic [31:0] CDR_WMASK         = 32'h00FF00FF;
    localparam logic [31:0] ERR_WMASK         = 32'hFFFFFFFF;
    localparam logic [31:0] ZERO_WORD         = 32'h00000000;
endpackage

// file: hw/acr_lane_swap.sv
`timescale 1ns/100ps
module acr_lane_swap
    import acr_pkg::*;
(
    input  wire logic        big_endian,
    input  wire logic [31:0] din,
    output logic      [31:0] dout
);
    // Big-endian swaps byte lanes so first wire byte lands in bits 31-24
    always_comb
    begin
        if (big_endian)
        begin
            dout = {din[7:0], din[15:8], din[23:16], din[31:24]};
        end
        else
        begin
            dout = din;
        end
    end
endmodule

// file: hw/acr_ctrl_regs.sv
`timescale 1ns/100ps
// What this block does
// - Bit 31 picks little or big endian
// - Bits 28-24 hold slave id for address match
// - Slave id ignored in single-PHY mode
// - Id 1Fh is null, never matches
// - Tx header field zero gives 53-byte cells
// - Tx values 1-11 add header, 54-64 bytes
// - Tx enable low holds transmitter in reset
// - Tx enable high releases transmitter
// - Bit 14 selects single or multi PHY
// - Multi-PHY selected after reset
// - Reserved bits read zero, writes ignored
// - Rx queue read 0000, tx queue write 0004
// - Decode control, clock, error enable, pending offsets
// - Bit 0 enables receiver, low holds reset
// - Soft reset idles engines, keeps registers
// - Bits 5-2 hold rx extra header length
module acr_ctrl_regs
    import acr_pkg::*;
#(
    parameter int AW = ACR_AW
)
(
    input  wire logic          mclk,
    input  wire logic          arst_n,
    input  wire logic          cfg_sel,
    input  wire logic          cfg_wr,
    input  wire logic          cfg_rd,
    input  wire logic [AW-1:0] cfg_addr,
    input  wire logic [31:0]   cfg_wdata,
    output logic      [31:0]   cfg_rdata,
    output logic               cfg_rvalid,
    output logic               cfg_err,
    input  wire logic          host_wr,
    input  wire logic [31:0]   host_wdata,
    input  wire logic          dp_wr,
    input  wire logic          dp_rd,
    input  wire logic [AW-1:0] dp_addr,
    input  wire logic [31:0]   dp_wdata,
    output logic      [31:0]   dp_rdata,
    output logic               dp_rvalid,
    output logic               dp_err,
    input  wire logic [31:0]   rx_word,
    output logic               rx_word_take,
    output logic      [31:0]   tx_word,
    output logic               tx_word_load,
    input  wire logic [4:0]    phy_addr,
    output logic               addr_match,
    output logic               byte_order_select,
    output logic               shared_bus_mode,
    output logic               tx_section_enable,
    output logic               rx_section_enable,
    output logic               tx_rst,
    output logic               rx_rst,
    output logic      [6:0]    tx_cell_bytes,
    output logic      [6:0]    rx_cell_bytes,
    output logic      [3:0]    tx_extra_header_len,
    output logic      [3:0]    rx_extra_header_len,
    output logic               tx_udc_bad
);
    // Offsets decode on five bits, so a narrower bus cannot reach the map
    if (AW < 5)
    begin
        $error("AW too narrow for the register map");
    end

    logic [31:0] port_control_reg;
    logic [31:0] clock_presence_check_reg;
    logic [31:0] error_irq_enable_reg;
    logic [31:0] error_irq_pending_reg;
    logic [31:0] rx_swapped;
    logic [31:0] tx_swapped;
    logic [4:0]  cfg_off;
    logic [4:0]  dp_off;
    logic [3:0]  tx_len;
    logic [3:0]  rx_len;

    assign cfg_off = cfg_addr[4:0];
    assign dp_off  = dp_addr[4:0];
    assign tx_len  = port_control_reg[POS_TXUDC_HI:POS_TXUDC_LO];
    assign rx_len  = port_control_reg[POS_RXUDC_HI:POS_RXUDC_LO];

    // Host port write wins a same-cycle clash; it is the rarer agent
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            port_control_reg <= CTRL_RESET;
        end
        else if (host_wr)
        begin
            port_control_reg <= host_wdata & CTRL_WMASK;
        end
        else if (cfg_sel && cfg_wr && cfg_off == OFF_PORT_CONTROL)
        begin
            port_control_reg <= cfg_wdata & CTRL_WMASK;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clock_presence_check_reg <= ZERO_WORD;
            error_irq_enable_reg     <= ZERO_WORD;
            error_irq_pending_reg    <= ZERO_WORD;
        end
        else if (cfg_sel && cfg_wr)
        begin
            if (cfg_off == OFF_CLOCK_CHECK)
            begin
                clock_presence_check_reg <= cfg_wdata & CDR_WMASK;
            end
            if (cfg_off == OFF_ERR_ENABLE)
            begin
                error_irq_enable_reg <= cfg_wdata & ERR_WMASK;
            end
            if (cfg_off == OFF_ERR_PENDING)
            begin
                // Pending layout is outside this block; write-one clears
                error_irq_pending_reg <= error_irq_pending_reg & ~cfg_wdata;
            end
        end
    end

    // Unmapped offsets answer zero with an error flag
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_rdata  <= ZERO_WORD;
            cfg_rvalid <= 1'b0;
            cfg_err    <= 1'b0;
        end
        else
        begin
            cfg_rvalid <= cfg_sel && cfg_rd;
            cfg_err    <= 1'b0;
            cfg_rdata  <= ZERO_WORD;
            if (cfg_sel && cfg_rd)
            begin
                unique case (cfg_off)
                    OFF_PORT_CONTROL: cfg_rdata <= port_control_reg;
                    OFF_CLOCK_CHECK:  cfg_rdata <= clock_presence_check_reg;
                    OFF_ERR_ENABLE:   cfg_rdata <= error_irq_enable_reg;
                    OFF_ERR_PENDING:  cfg_rdata <= error_irq_pending_reg;
                    default:          cfg_err   <= 1'b1;
                endcase
            end
        end
    end

    acr_lane_swap u_rx_swap
    (
        .big_endian (port_control_reg[POS_BYTE_ORDER]),
        .din        (rx_word),
        .dout       (rx_swapped)
    );

    acr_lane_swap u_tx_swap
    (
        .big_endian (port_control_reg[POS_BYTE_ORDER]),
        .din        (dp_wdata),
        .dout       (tx_swapped)
    );

    // Data port: rx queue read-only, tx queue write-only
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dp_rdata     <= ZERO_WORD;
            dp_rvalid    <= 1'b0;
            dp_err       <= 1'b0;
            rx_word_take <= 1'b0;
            tx_word      <= ZERO_WORD;
            tx_word_load <= 1'b0;
        end
        else
        begin
            dp_rvalid    <= dp_rd;
            dp_rdata     <= ZERO_WORD;
            rx_word_take <= 1'b0;
            tx_word_load <= 1'b0;
            dp_err       <= (dp_rd && dp_off != OFF_RX_QUEUE)
                          || (dp_wr && dp_off != OFF_TX_QUEUE);
            if (dp_rd && dp_off == OFF_RX_QUEUE)
            begin
                dp_rdata     <= rx_swapped;
                rx_word_take <= 1'b1;
            end
            // Words to a held transmitter are dropped, not queued
            if (dp_wr && dp_off == OFF_TX_QUEUE && port_control_reg[POS_TX_EN])
            begin
                tx_word      <= tx_swapped;
                tx_word_load <= 1'b1;
            end
        end
    end

    // Outputs registered; one cycle after the control word changes
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            byte_order_select   <= 1'b0;
            shared_bus_mode     <= 1'b1;
            tx_section_enable   <= 1'b0;
            rx_section_enable   <= 1'b0;
            tx_rst              <= 1'b1;
            rx_rst              <= 1'b1;
            tx_extra_header_len <= 4'h0;
            rx_extra_header_len <= 4'h0;
            tx_cell_bytes       <= STD_CELL_BYTES;
            rx_cell_bytes       <= STD_CELL_BYTES;
            tx_udc_bad          <= 1'b0;
            addr_match          <= 1'b0;
        end
        else
        begin
            byte_order_select   <= port_control_reg[POS_BYTE_ORDER];
            shared_bus_mode     <= port_control_reg[POS_SHARED];
            tx_section_enable   <= port_control_reg[POS_TX_EN];
            rx_section_enable   <= port_control_reg[POS_RX_EN];
            // Soft reset touches only the engines, never these registers
            tx_rst              <= !port_control_reg[POS_TX_EN];
            rx_rst              <= !port_control_reg[POS_RX_EN];
            tx_extra_header_len <= tx_len;
            rx_extra_header_len <= rx_len;
            // Reserved codes are clamped to standard cells as a safe fallback
            tx_cell_bytes       <= (tx_len > UDC_MAX) ? STD_CELL_BYTES
                                 : STD_CELL_BYTES + {3'h0, tx_len};
            rx_cell_bytes       <= (rx_len > UDC_MAX) ? STD_CELL_BYTES
                                 : STD_CELL_BYTES + {3'h0, rx_len};
            tx_udc_bad          <= tx_len > UDC_MAX;
            if (!port_control_reg[POS_SHARED])
            begin
                addr_match <= 1'b1;
            end
            else
            begin
                addr_match <= phy_addr != NULL_SLAVE
                    && phy_addr == port_control_reg[POS_SLAVE_IDENTIFIER_HI:POS_SLAVE_IDENTIFIER_LO];
            end
        end
    end

    reserved_zero_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (port_control_reg & ~CTRL_WMASK) == ZERO_WORD)
        else $error("reserved control bit set");

    ctrl_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
        cfg_sel && cfg_wr && cfg_off == OFF_PORT_CONTROL && !host_wr
        |=> port_control_reg == ($past(cfg_wdata) & CTRL_WMASK))
        else $error("control write not taken next edge");

    host_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
        host_wr |=> port_control_reg == ($past(host_wdata) & CTRL_WMASK))
        else $error("host control write not taken");

    soft_keep_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !host_wr && !(cfg_sel && cfg_wr && cfg_off == OFF_PORT_CONTROL)
        |=> $stable(port_control_reg))
        else $error("control word changed without a write");

    tx_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !port_control_reg[POS_TX_EN] |=> tx_rst && !tx_section_enable)
        else $error("transmitter not held in reset");

    tx_release_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(port_control_reg[POS_TX_EN]) |=> !tx_rst)
        else $error("transmitter not released");

    tx_run_a: assert property (@(posedge mclk) disable iff (!arst_n)
        port_control_reg[POS_TX_EN] |=> tx_section_enable && !tx_rst)
        else $error("transmitter not enabled");

    tx_drop_a: assert property (@(posedge mclk) disable iff (!arst_n)
        dp_wr && !port_control_reg[POS_TX_EN] |=> !tx_word_load)
        else $error("word loaded into held transmitter");

    rx_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !port_control_reg[POS_RX_EN] |=> rx_rst)
        else $error("receiver not held in reset");

    rx_release_a: assert property (@(posedge mclk) disable iff (!arst_n)
        port_control_reg[POS_RX_EN] |=> !rx_rst && rx_section_enable)
        else $error("receiver not released");

    std_cell_a: assert property (@(posedge mclk) disable iff (!arst_n)
        tx_len == 4'h0 |=> tx_cell_bytes == 7'h35)
        else $error("standard cell not 53 bytes");

    udc_cell_a: assert property (@(posedge mclk) disable iff (!arst_n)
        tx_len == UDC_MAX |=> tx_cell_bytes == 7'h40)
        else $error("longest cell not 64 bytes");

    udc_range_a: assert property (@(posedge mclk) disable iff (!arst_n)
        tx_len != 4'h0 && tx_len <= UDC_MAX
        |=> tx_cell_bytes > 7'h35 && tx_cell_bytes <= 7'h40)
        else $error("extended cell length out of range");

    rx_std_cell_a: assert property (@(posedge mclk) disable iff (!arst_n)
        rx_len == 4'h0 |=> rx_cell_bytes == 7'h35)
        else $error("standard receive cell not 53 bytes");

    null_slave_a: assert property (@(posedge mclk) disable iff (!arst_n)
        port_control_reg[POS_SHARED] && phy_addr == 5'h1F |=> !addr_match)
        else $error("null address matched");

    single_phy_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !port_control_reg[POS_SHARED] |=> addr_match)
        else $error("slave id used in single mode");

    slave_match_a: assert property (@(posedge mclk) disable iff (!arst_n)
        port_control_reg[POS_SHARED] && phy_addr != 5'h1F
        && phy_addr == port_control_reg[POS_SLAVE_IDENTIFIER_HI:POS_SLAVE_IDENTIFIER_LO] |=> addr_match)
        else $error("own slave address not matched");

    shared_mode_a: assert property (@(posedge mclk) disable iff (!arst_n)
        1'b1 |=> shared_bus_mode == $past(port_control_reg[POS_SHARED]))
        else $error("bus mode output wrong");

    byte_order_a: assert property (@(posedge mclk) disable iff (!arst_n)
        1'b1 |=> byte_order_select == $past(port_control_reg[POS_BYTE_ORDER]))
        else $error("byte order output wrong");

    endian_swap_a: assert property (@(posedge mclk) disable iff (!arst_n)
        dp_rd && dp_off == OFF_RX_QUEUE && port_control_reg[POS_BYTE_ORDER]
        |=> dp_rdata[7:0] == $past(rx_word[31:24]))
        else $error("big-endian lane order wrong");

    tx_lanes_a: assert property (@(posedge mclk) disable iff (!arst_n)
        dp_wr && dp_off == OFF_TX_QUEUE && port_control_reg[POS_TX_EN]
        && !port_control_reg[POS_BYTE_ORDER]
        |=> tx_word_load && tx_word == $past(dp_wdata))
        else $error("little-endian word altered");

    rx_queue_ro_a: assert property (@(posedge mclk) disable iff (!arst_n)
        dp_wr && dp_off == OFF_RX_QUEUE |=> dp_err && !tx_word_load)
        else $error("write to receive queue accepted");

    cfg_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
        cfg_sel && cfg_rd && cfg_off == OFF_CLOCK_CHECK
        |=> cfg_rvalid && !cfg_err && cfg_rdata == $past(clock_presence_check_reg))
        else $error("clock check read wrong");

    cfg_unmap_a: assert property (@(posedge mclk) disable iff (!arst_n)
        cfg_sel && cfg_rd && cfg_off == 5'h08 |=> cfg_err && cfg_rdata == ZERO_WORD)
        else $error("unmapped read not flagged");
endmodule

// file: testbench/acr_rxq_model.sv
`timescale 1ns/100ps
module acr_rxq_model
    import acr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        rx_word_take,
    output logic      [31:0] rx_word
);
    // Head word pops on every take, so a missed take shows as a stale word
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rx_word <= 32'h11223344;
        else if (rx_word_take)
            rx_word <= rx_word + 32'h01010101;
    end
endmodule

// file: testbench/tb_atm_cell_slave_control_regs.sv
`timescale 1ns/100ps
module tb_atm_cell_slave_control_regs
    import acr_pkg::*;
;
    logic        mclk = 0, arst_n = 0, cfg_sel = 0, cfg_wr = 0, cfg_rd = 0;
    logic        host_wr = 0, dp_wr = 0, dp_rd = 0;
    logic [4:0]  cfg_addr = 0, dp_addr = 0, phy_addr = 0;
    logic [31:0] cfg_wdata = 0, host_wdata = 0, dp_wdata = 0;
    logic [31:0] cfg_rdata, dp_rdata, rx_word, tx_word, v;
    logic        cfg_rvalid, cfg_err, dp_rvalid, dp_err, rx_word_take, tx_word_load;
    logic        addr_match, byte_order_select, shared_bus_mode, tx_udc_bad;
    logic        tx_section_enable, rx_section_enable, tx_rst, rx_rst;
    logic [6:0]  tx_cell_bytes, rx_cell_bytes;
    logic [3:0]  tx_extra_header_len, rx_extra_header_len;
    logic [31:0] rq = 32'h11223344;
    int          error_cnt = 0, n_compared = 0;

    acr_ctrl_regs i_acr_ctrl_regs (.mclk(mclk), .arst_n(arst_n), .cfg_sel(cfg_sel),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .cfg_err(cfg_err),
        .host_wr(host_wr), .host_wdata(host_wdata), .dp_wr(dp_wr), .dp_rd(dp_rd),
        .dp_addr(dp_addr), .dp_wdata(dp_wdata), .dp_rdata(dp_rdata),
        .dp_rvalid(dp_rvalid), .dp_err(dp_err), .rx_word(rx_word),
        .rx_word_take(rx_word_take), .tx_word(tx_word), .tx_word_load(tx_word_load),
        .phy_addr(phy_addr), .addr_match(addr_match),
        .byte_order_select(byte_order_select), .shared_bus_mode(shared_bus_mode),
        .tx_section_enable(tx_section_enable), .rx_section_enable(rx_section_enable),
        .tx_rst(tx_rst), .rx_rst(rx_rst), .tx_cell_bytes(tx_cell_bytes),
        .rx_cell_bytes(rx_cell_bytes), .tx_extra_header_len(tx_extra_header_len),
        .rx_extra_header_len(rx_extra_header_len), .tx_udc_bad(tx_udc_bad));
    acr_rxq_model i_acr_rxq_model (.mclk(mclk), .arst_n(arst_n),
        .rx_word_take(rx_word_take), .rx_word(rx_word));

    always #2.5 mclk = ~mclk;

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    // One extra edge so derived outputs have settled
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        cfg_sel <= 1; cfg_wr <= 1; cfg_addr <= a; cfg_wdata <= d;
        @(posedge mclk);
        cfg_sel <= 0; cfg_wr <= 0;
        @(posedge mclk);
        #1;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge mclk);
        cfg_sel <= 1; cfg_rd <= 1; cfg_addr <= a;
        @(posedge mclk);
        cfg_sel <= 0; cfg_rd <= 0;
        #1;
        chk("rvalid", 1, cfg_rvalid);
        v = cfg_rdata;
    endtask
    task automatic dp(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        dp_wr <= w; dp_rd <= !w; dp_addr <= a; dp_wdata <= d;
        @(posedge mclk);
        dp_wr <= 0; dp_rd <= 0;
        #1;
    endtask
    function automatic logic [31:0] sw(input logic [31:0] d);
        return {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction

    task automatic t_reset;
        rd(OFF_PORT_CONTROL);
        chk("ctrl", 32'h00004000, v);
        chk("txrst", 1, tx_rst);
        chk("rxrst", 1, rx_rst);
        chk("txbytes", 53, tx_cell_bytes);
        $display("test reset done");
    endtask
    task automatic t_resv;
        wr(OFF_PORT_CONTROL, 32'hFFC3FFC3);
        rd(OFF_PORT_CONTROL);
        chk("ctrl", 32'h9F014001, v);
        chk("byte_order_select", 1, byte_order_select);
        chk("txrst", 0, tx_rst);
        chk("txen", 1, tx_section_enable);
        chk("rxrst", 0, rx_rst);
        $display("test reserved done");
    endtask
    task automatic t_udc;
        for (int k = 0; k < 16; k++)
        begin
            // Codes above 11 are sent on purpose to see them rejected
            wr(OFF_PORT_CONTROL, 32'h00014001 | (k << 18) | (k << 2));
            chk("txbytes", (k <= 11) ? 53 + k : 53, tx_cell_bytes);
            chk("rxbytes", (k <= 11) ? 53 + k : 53, rx_cell_bytes);
            chk("udcbad", k > 11, tx_udc_bad);
            chk("txlen", k, tx_extra_header_len);
            chk("rxlen", k, rx_extra_header_len);
        end
        $display("test cell length done");
    endtask
    task automatic am(input logic m, input logic [4:0] s, input logic [4:0] p, input logic e);
        @(posedge mclk);
        phy_addr <= p;
        wr(OFF_PORT_CONTROL, (m << 14) | (s << 24));
        chk("mode", m, shared_bus_mode);
        chk("match", e, addr_match);
    endtask
    task automatic t_addr;
        am(1, 5'h05, 5'h05, 1);
        am(1, 5'h05, 5'h06, 0);
        am(1, 5'h1F, 5'h1F, 0);
        am(0, 5'h05, 5'h06, 1);
        $display("test address done");
    endtask
    task automatic t_dp;
        wr(OFF_PORT_CONTROL, 32'h80014000);
        dp(1, OFF_TX_QUEUE, 32'hA1B2C3D4);
        chk("load", 1, tx_word_load);
        chk("txbig", sw(32'hA1B2C3D4), tx_word);
        dp(0, OFF_RX_QUEUE, 0);
        chk("take", 1, rx_word_take);
        chk("dpvalid", 1, dp_rvalid);
        chk("rxbig", sw(rq), dp_rdata);
        rq = rq + 32'h01010101;
        wr(OFF_PORT_CONTROL, 32'h00014000);
        dp(1, OFF_TX_QUEUE, 32'h5566778F);
        chk("txlit", 32'h5566778F, tx_word);
        dp(0, OFF_RX_QUEUE, 0);
        chk("rxlit", rq, dp_rdata);
        dp(0, 5'h08, 0);
        chk("dperr", 1, dp_err);
        wr(OFF_PORT_CONTROL, 32'h00004000);
        dp(1, OFF_TX_QUEUE, 32'h01020304);
        chk("noload", 0, tx_word_load);
        $display("test data port done");
    endtask
    task automatic t_cfg;
        wr(OFF_CLOCK_CHECK, 32'hFFFFFFFF);
        rd(OFF_CLOCK_CHECK);
        chk("clk", 32'h00FF00FF, v);
        wr(OFF_ERR_ENABLE, 32'hA5A5A5A5);
        rd(OFF_ERR_ENABLE);
        chk("eie", 32'hA5A5A5A5, v);
        wr(OFF_ERR_PENDING, 32'hFFFFFFFF);
        rd(OFF_ERR_PENDING);
        chk("eip", 0, v);
        rd(5'h08);
        chk("cfgerr", 1, cfg_err);
        chk("unmap", 0, v);
        $display("test config map done");
    endtask
    task automatic t_host;
        @(posedge mclk);
        host_wr <= 1; host_wdata <= 32'h85004001;
        @(posedge mclk);
        host_wr <= 0;
        rd(OFF_PORT_CONTROL);
        chk("host", 32'h85004001, v);
        chk("rxen", 1, rx_section_enable);
        // Clearing the rx enable (tx enable already low) is a soft reset that must keep the fields
        wr(OFF_PORT_CONTROL, 32'h85004000);
        rd(OFF_PORT_CONTROL);
        chk("keep", 32'h85004000, v);
        chk("rxrst", 1, rx_rst);
        // Same-cycle clash: the host word must win over the local one
        @(posedge mclk);
        host_wr <= 1;
        host_wdata <= 32'h00004000;
        cfg_sel <= 1;
        cfg_wr <= 1;
        cfg_addr <= OFF_PORT_CONTROL;
        cfg_wdata <= 32'h80014001;
        @(posedge mclk);
        host_wr <= 0;
        cfg_sel <= 0;
        cfg_wr <= 0;
        rd(OFF_PORT_CONTROL);
        chk("clash", 32'h00004000, v);
        $display("test host done");
    endtask

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge mclk);
        arst_n <= 1;
        t_reset();
        t_resv();
        t_udc();
        t_addr();
        t_dp();
        t_cfg();
        t_host();
        give_verdict();
    end
    // The run needs under 150 cycles; this span of 10000 cycles is far beyond that
    initial
    begin
        #50000;
        error_cnt++;
        give_verdict();
    end
endmodule
